// ### pvd_pkg.sv
// constants, types and register layout for the pci video dma front end
package pvd_pkg;
  localparam int NCH = 3;
  localparam int FIFO_DWORDS = 128;
  localparam int LVL_W = 8;
  // configuration header offsets
  localparam logic [7:0] CFG_IDS = 8'h00;
  localparam logic [7:0] CFG_STCMD = 8'h04;
  localparam logic [7:0] CFG_CLASS = 8'h08;
  localparam logic [7:0] CFG_LAT = 8'h0C;
  localparam logic [7:0] CFG_BAR = 8'h10;
  localparam logic [7:0] CFG_SUBSYS = 8'h2C;
  localparam logic [7:0] CFG_INTR = 8'h3C;
  localparam logic [23:0] CLASS_CODE = 24'h048000;
  localparam logic [31:0] STAT_FIXED = 32'h0280_0000;
  localparam logic [31:0] STAT_W1C = 32'hB100_0000;
  localparam logic [31:0] CMD_MASK = 32'h0000_0246;
  localparam int ST_DPE = 31;
  localparam int ST_RMA = 29;
  localparam int ST_RTA = 28;
  localparam int ST_DPD = 24;
  localparam int CMD_BME = 2;
  localparam int CMD_MEM = 1;
  localparam int BAR_LO = 9;
  localparam int LAT_LO = 8;
  localparam logic [7:0] MAX_LAT_DEF = 8'h26;
  localparam logic [7:0] MIN_GNT_DEF = 8'h0F;
  localparam logic [31:0] SUBSYS_DEF = 32'h0000_0000;
  localparam logic [7:0] INT_PIN_A = 8'h01;
  localparam logic [6:0] EE_DEV_ADDR = 7'h50;
  localparam int EE_BYTES = 6;
  localparam logic [3:0] EE_LAST_STEP = 4'h8;
  // serial memory bit time, split in quarters
  localparam int CLK_NS = 50;
  localparam int EE_BIT_NS = 10000;
  localparam int EE_QTR_CYC = EE_BIT_NS / (4 * CLK_NS);
  // channel window: 8 words per channel
  localparam int CH_LO = 5;
  localparam logic [2:0] CR_BASE_ODD = 3'h0;
  localparam logic [2:0] CR_BASE_EVEN = 3'h1;
  localparam logic [2:0] CR_PROT = 3'h2;
  localparam logic [2:0] CR_PITCH = 3'h3;
  localparam logic [2:0] CR_PAGE = 3'h4;
  localparam logic [2:0] CR_NUM = 3'h5;
  localparam logic [2:0] CR_CTRL = 3'h6;
  localparam logic [2:0] CR_STAT = 3'h7;
  localparam logic [31:0] PROT_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] PAGE_MASK = 32'hFFFF_F8FB;
  localparam logic [31:0] NUM_MASK = 32'h0FFF_0FFF;
  localparam logic [31:0] CTRL_MASK = 32'h00FF_FF0F;
  localparam logic [31:0] CTRL3_MASK = 32'h03FF_FF0F;
  localparam int CTL_EN = 0;
  localparam int CTL_MODE_LO = 1;
  localparam int CTL_THR_LO = 8;
  localparam int CTL_BURST_LO = 16;
  localparam int CTL_REP_LO = 24;
  localparam int NUM_LINES_LO = 16;
  localparam int SWAP_LO = 0;
  typedef enum logic [2:0] {MODE_PLANAR, MODE_CLIP, MODE_CHROMA, MODE_BYPASS, MODE_READ} pvd_mode_t;
  typedef struct packed {
    logic cfg;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } pvd_acc_t;
  typedef struct packed {
    logic write;
    logic [1:0] chan;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pvd_mreq_t;
endpackage

// ### pvd_dma.sv
// config header, serial memory loader and three video dma channels
// What this block does
// - read-only revision byte in class word
// - writable latency timer bounds master bursts
// - base register upper bits writable, low zero
// - load ids and timing from serial memory
// - interrupt pin field reads first line
// - three channels: fifo, video and pci control
// - first channel only writes to memory
// - 128-dword fifos; first carries scaler output
// - planar: second U, third V to memory
// - clip mode: second channel fetches clip data
// - chroma key: third channel writes key data
// - bypass scaler: third channel writes its output
// - read mode: third fetches, repeats up to four
// - per-channel bases, pitch, protection, page, mode, enable
// - per-channel threshold and burst steer arbitration
// - second, third count pixels, lines; third scales
// - settings reload when the control word is rewritten
// - registers decoded at base plus offset
// - retry every access while loading
// - serial memory read at address 1010000
// - unimplemented config words read zero
`timescale 1ns/100ps
`default_nettype none
module pvd_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 128,
  parameter int LW = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready,
  output logic [LW-1:0] o_level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [LW-1:0] cnt_ff;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = cnt_ff != LW'(DEPTH);
  assign o_out_valid = cnt_ff != '0;
  assign o_out_data = mem_ff[rd_ff];
  assign o_level = cnt_ff;
  always_ff @(posedge i_clk) begin
    if (push) mem_ff[wr_ff] <= i_in_data;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + LW'(push) - LW'(pop);
    end
  end
endmodule

module pvd_dma import pvd_pkg::*; #(
  parameter logic [15:0] MAKER_CODE = 16'hA5A5, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h5A5A, // arbitrary value
  parameter logic [7:0] REV_CODE = 8'h3C // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_acc_valid,
  input wire pvd_acc_t i_acc,
  output logic o_acc_ack,
  output logic o_acc_retry,
  output logic [31:0] o_acc_rdata,
  input wire logic i_evt_parity,
  input wire logic i_evt_mabort,
  input wire logic i_evt_tabort,
  input wire logic i_evt_dparity,
  output logic o_mst_valid,
  output pvd_mreq_t o_mst_req,
  input wire logic i_mst_ready,
  input wire logic [31:0] i_mst_rdata,
  input wire logic i_vid_odd,
  input wire logic [NCH-1:0] i_vid_valid,
  input wire logic [NCH-1:0][31:0] i_vid_data,
  input wire logic [NCH-1:0] i_vid_eof,
  output logic [NCH-1:0] o_vid_ready,
  output logic [NCH-1:0] o_rd_valid,
  output logic [NCH-1:0][31:0] o_rd_data,
  input wire logic [NCH-1:0] i_rd_ready,
  output logic o_ee_scl_o,
  output logic o_ee_scl_oe,
  output logic o_ee_sda_o,
  output logic o_ee_sda_oe,
  input wire logic i_ee_sda_i
);
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) o[8*i +: 8] = n[8*i +: 8];
    end
    return o;
  endfunction

  // ---------------- serial memory loader ----------------
  typedef enum {LD_START, LD_BYTE, LD_STOP, LD_DONE} pvd_ld_t;
  pvd_ld_t ld_ff;
  logic [7:0] qcnt_ff;
  logic [1:0] q_ff;
  logic [3:0] bit_ff;
  logic [3:0] step_ff;
  logic [7:0] sh_ff;
  logic [8*EE_BYTES-1:0] got_ff;
  logic nak_ff;
  logic scl_ff;
  logic sda_ff;
  logic sy1_ff, sy2_ff, sy3_ff, sda_in_ff;
  logic [31:0] subsys_ff;
  logic [7:0] max_lat_ff;
  logic [7:0] min_gnt_ff;
  wire qtick = qcnt_ff == 8'(EE_QTR_CYC - 1);
  wire loading = ld_ff != LD_DONE;
  wire ee_rd = step_ff >= 4'h3;
  wire ack_bit = bit_ff == 4'h8;
  wire [7:0] tx_byte = step_ff == 4'h0 ? {EE_DEV_ADDR, 1'b0} :
                       step_ff == 4'h2 ? {EE_DEV_ADDR, 1'b1} : 8'h00;
  wire bit_sda = ack_bit ? (ee_rd ? step_ff == EE_LAST_STEP : 1'b1) :
                 (ee_rd ? 1'b1 : tx_byte[3'(7 - bit_ff)]);
  assign o_ee_scl_o = 1'b0;
  assign o_ee_sda_o = 1'b0;
  assign o_ee_scl_oe = !scl_ff;
  assign o_ee_sda_oe = !sda_ff;
  always_ff @(posedge i_clk) begin
    sy1_ff <= i_ee_sda_i;
    sy2_ff <= sy1_ff;
    sy3_ff <= sy2_ff;
    if (sy2_ff == sy3_ff) sda_in_ff <= sy3_ff;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ld_ff <= LD_START;
      qcnt_ff <= '0;
      q_ff <= '0;
      bit_ff <= '0;
      step_ff <= '0;
      nak_ff <= 1'b0;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      sh_ff <= '0;
      got_ff <= '0;
      subsys_ff <= SUBSYS_DEF;
      max_lat_ff <= MAX_LAT_DEF;
      min_gnt_ff <= MIN_GNT_DEF;
    end else if (loading) begin
      qcnt_ff <= qtick ? '0 : qcnt_ff + 8'h01;
      if (qtick) begin
        q_ff <= q_ff + 2'h1;
        unique case (ld_ff)
          LD_START: begin
            unique case (q_ff)
              2'h0: begin scl_ff <= 1'b1; sda_ff <= 1'b1; end
              2'h1: sda_ff <= 1'b0;
              2'h2: scl_ff <= 1'b0;
              2'h3: begin ld_ff <= LD_BYTE; bit_ff <= '0; end
            endcase
          end
          LD_BYTE: begin
            unique case (q_ff)
              2'h0: sda_ff <= bit_sda;
              2'h1: scl_ff <= 1'b1;
              2'h2: begin
                if (!ack_bit) sh_ff <= {sh_ff[6:0], sda_in_ff};
                else if (!ee_rd && sda_in_ff) nak_ff <= 1'b1;
              end
              2'h3: begin
                scl_ff <= 1'b0;
                bit_ff <= bit_ff + 4'h1;
                if (ack_bit) begin
                  bit_ff <= '0;
                  step_ff <= step_ff + 4'h1;
                  if (ee_rd) got_ff <= {sh_ff, got_ff[8*EE_BYTES-1:8]};
                  if (nak_ff || step_ff == EE_LAST_STEP) ld_ff <= LD_STOP;
                  else if (step_ff == 4'h1) ld_ff <= LD_START;
                end
              end
            endcase
          end
          LD_STOP: begin
            unique case (q_ff)
              2'h0: sda_ff <= 1'b0;
              2'h1: scl_ff <= 1'b1;
              2'h2: sda_ff <= 1'b1;
              2'h3: begin
                ld_ff <= LD_DONE;
                if (!nak_ff) begin // defaults stay when the memory does not answer
                  subsys_ff <= got_ff[31:0];
                  min_gnt_ff <= got_ff[39:32];
                  max_lat_ff <= got_ff[47:40];
                end
              end
            endcase
          end
          default: ;
        endcase
      end
    end
  end

  // ---------------- configuration header and access decode ----------------
  logic [31:0] stcmd_ff;
  logic [7:0] lat_ff;
  logic [31:BAR_LO] bar_ff;
  logic [7:0] int_line_ff;
  logic ack_ff, retry_ff;
  logic [31:0] rdata_ff;
  wire [7:0] coff = {i_acc.addr[7:2], 2'b00};
  wire bar_hit = i_acc.addr[31:BAR_LO] == bar_ff && stcmd_ff[CMD_MEM];
  wire claim = i_acc_valid && (i_acc.cfg || bar_hit);
  wire take = claim && !loading;
  wire cfg_wr = take && i_acc.cfg && i_acc.wr;
  wire mem_wr = take && !i_acc.cfg && i_acc.wr;
  wire [1:0] wch = i_acc.addr[CH_LO +: 2];
  wire [2:0] widx = i_acc.addr[4:2];
  wire [31:0] evt = {i_evt_parity, 1'b0, i_evt_mabort, i_evt_tabort, 3'b000, i_evt_dparity, 24'h0};
  wire [31:0] cfg_word =
    coff == CFG_IDS ? {PART_CODE, MAKER_CODE} :
    coff == CFG_STCMD ? (stcmd_ff | STAT_FIXED) :
    coff == CFG_CLASS ? {CLASS_CODE, REV_CODE} :
    coff == CFG_LAT ? {16'h0, lat_ff, 8'h0} :
    coff == CFG_BAR ? {bar_ff, 9'h0} :
    coff == CFG_SUBSYS ? subsys_ff :
    coff == CFG_INTR ? {max_lat_ff, min_gnt_ff, INT_PIN_A, int_line_ff} :
    32'h0;
  logic [NCH-1:0][31:0] ch_rword;
  wire [31:0] mem_word = wch < 2'(NCH) ? ch_rword[wch] : 32'h0;
  wire [31:0] st_wr = be_merge(32'h0, i_acc.wdata, i_acc.be);
  // merged words as named wires: a function result cannot be part-selected
  wire [31:0] cmd_merge = be_merge(stcmd_ff, i_acc.wdata, i_acc.be);
  wire [31:0] bar_merge = be_merge({bar_ff, 9'h0}, i_acc.wdata, i_acc.be);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stcmd_ff <= '0;
      lat_ff <= '0;
      bar_ff <= '0;
      int_line_ff <= '0;
    end else begin
      // a flag event in the same cycle as its clear keeps the flag
      stcmd_ff <= (stcmd_ff & ~(cfg_wr && coff == CFG_STCMD ? st_wr & STAT_W1C : 32'h0)) | evt;
      if (cfg_wr && coff == CFG_STCMD) begin
        stcmd_ff[15:0] <= cmd_merge[15:0] & CMD_MASK[15:0];
      end
      if (cfg_wr && coff == CFG_LAT && i_acc.be[1]) lat_ff <= i_acc.wdata[LAT_LO +: 8];
      if (cfg_wr && coff == CFG_BAR) begin
        bar_ff <= bar_merge[31:BAR_LO];
      end
      if (cfg_wr && coff == CFG_INTR && i_acc.be[0]) int_line_ff <= i_acc.wdata[7:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_ff <= 1'b0;
      retry_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= take;
      retry_ff <= claim && loading;
      if (take && !i_acc.wr) rdata_ff <= i_acc.cfg ? cfg_word : mem_word;
    end
  end
  assign o_acc_ack = ack_ff;
  assign o_acc_retry = retry_ff;
  assign o_acc_rdata = rdata_ff;

  // ---------------- video channels ----------------
  typedef enum {MS_IDLE, MS_BURST} pvd_ms_t;
  pvd_ms_t ms_ff;
  logic [1:0] sel_ff;
  logic [7:0] bcnt_ff;
  logic [7:0] lcnt_ff;
  logic [NCH-1:0] rd_mode, want, can, last, beat_c;
  logic [NCH-1:0][31:0] ch_addr, ch_out;
  logic [NCH-1:0][7:0] ch_burst;
  logic [NCH-1:0][1:0] ch_swap;
  wire bme = stcmd_ff[CMD_BME];
  wire beat = o_mst_valid && i_mst_ready;
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [31:0] cr_ff [8];
    logic done_ff, eofp_ff;
    logic [31:0] addr_ff, line_ff;
    logic [11:0] wcnt_ff, lines_ff;
    logic [1:0] rep_ff;
    logic [LVL_W-1:0] lvl;
    logic f_in_rdy, f_out_vld;
    logic [31:0] f_out;
    wire pvd_mode_t mode = pvd_mode_t'(cr_ff[CR_CTRL][CTL_MODE_LO +: 3]);
    wire is_rd = (c == 1 && mode == MODE_CLIP) || (c == 2 && mode == MODE_READ);
    wire en = cr_ff[CR_CTRL][CTL_EN];
    wire [11:0] ppl = cr_ff[CR_NUM][11:0];
    wire [11:0] lpf = cr_ff[CR_NUM][NUM_LINES_LO +: 12];
    wire [1:0] reps = cr_ff[CR_CTRL][CTL_REP_LO +: 2];
    wire ctl_wr = mem_wr && bar_hit && wch == 2'(c) && widx == CR_CTRL;
    wire my_beat = beat && sel_ff == 2'(c);
    wire line_end = is_rd && ppl != '0 && wcnt_ff + 12'h1 == ppl;
    wire rep_more = line_end && rep_ff != reps;
    wire field_end = line_end && !rep_more && lines_ff + 12'h1 == lpf;
    wire prot_hit = cr_ff[CR_PROT] != '0 && addr_ff == cr_ff[CR_PROT];
    wire wr_done = !is_rd && eofp_ff && !f_out_vld && !(ms_ff == MS_BURST && sel_ff == 2'(c));
    wire [31:0] wmask = c == 2 ? CTRL3_MASK : CTRL_MASK;
    wire [31:0] wval = be_merge(cr_ff[widx], i_acc.wdata, i_acc.be);
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        for (int k = 0; k < 8; k++) cr_ff[k] <= '0;
      end else if (mem_wr && bar_hit && wch == 2'(c)) begin
        unique case (widx)
          CR_PROT: cr_ff[widx] <= wval & PROT_MASK;
          CR_PAGE: cr_ff[widx] <= wval & PAGE_MASK;
          CR_NUM: cr_ff[widx] <= c == 0 ? 32'h0 : wval & NUM_MASK;
          CR_CTRL: cr_ff[widx] <= wval & wmask;
          CR_STAT: ;
          default: cr_ff[widx] <= wval;
        endcase
      end
    end
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        done_ff <= 1'b0;
        eofp_ff <= 1'b0;
        addr_ff <= '0;
        line_ff <= '0;
        wcnt_ff <= '0;
        lines_ff <= '0;
        rep_ff <= '0;
      end else begin
        // a rewrite of the control word rearms the job; a done raised now survives it
        if (ctl_wr) begin
          done_ff <= 1'b0;
          eofp_ff <= 1'b0;
          addr_ff <= i_vid_odd ? cr_ff[CR_BASE_ODD] : cr_ff[CR_BASE_EVEN];
          line_ff <= i_vid_odd ? cr_ff[CR_BASE_ODD] : cr_ff[CR_BASE_EVEN];
          wcnt_ff <= '0;
          lines_ff <= '0;
          rep_ff <= '0;
        end
        if (i_vid_eof[c] && en && !is_rd) eofp_ff <= 1'b1;
        if (wr_done || (my_beat && field_end)) done_ff <= 1'b1;
        if (my_beat) begin
          addr_ff <= addr_ff + 32'h4;
          wcnt_ff <= wcnt_ff + 12'h1;
          if (line_end) begin
            wcnt_ff <= '0;
            if (rep_more) begin // same line fetched again for upscaling
              rep_ff <= rep_ff + 2'h1;
              addr_ff <= line_ff;
            end else begin
              rep_ff <= '0;
              lines_ff <= lines_ff + 12'h1;
              line_ff <= line_ff + cr_ff[CR_PITCH];
              addr_ff <= line_ff + cr_ff[CR_PITCH];
            end
          end
        end
      end
    end
    pvd_fifo #(.W(32), .DEPTH(FIFO_DWORDS), .LW(LVL_W)) u_fifo (
      .i_clk(i_clk),
      .i_rst(i_rst || ctl_wr),
      .i_in_valid(is_rd ? my_beat : i_vid_valid[c] && en),
      .i_in_data(is_rd ? i_mst_rdata : i_vid_data[c]),
      .o_in_ready(f_in_rdy),
      .o_out_valid(f_out_vld),
      .o_out_data(f_out),
      .i_out_ready(is_rd ? i_rd_ready[c] : my_beat),
      .o_level(lvl)
    );
    // write modes (planar, chroma key, bypass scaler) share the video-in path
    assign o_vid_ready[c] = !is_rd && en && f_in_rdy;
    assign o_rd_valid[c] = is_rd && f_out_vld;
    assign o_rd_data[c] = f_out;
    assign rd_mode[c] = is_rd;
    assign want[c] = en && !done_ff && !prot_hit && bme &&
      (is_rd ? LVL_W'(FIFO_DWORDS) - lvl >= cr_ff[CR_CTRL][CTL_THR_LO +: 8]
             : lvl >= cr_ff[CR_CTRL][CTL_THR_LO +: 8] && lvl != '0);
    assign can[c] = is_rd ? f_in_rdy && !done_ff && !prot_hit : f_out_vld && !prot_hit;
    assign last[c] = field_end;
    assign beat_c[c] = my_beat;
    assign ch_addr[c] = addr_ff;
    assign ch_out[c] = f_out;
    assign ch_burst[c] = cr_ff[CR_CTRL][CTL_BURST_LO +: 8];
    assign ch_swap[c] = cr_ff[CR_PAGE][SWAP_LO +: 2];
    assign ch_rword[c] = widx == CR_STAT ? {23'h0, lvl, done_ff} : cr_ff[widx];
  end

  // ---------------- master scheduling ----------------
  wire [1:0] pick = want[0] ? 2'd0 : want[1] ? 2'd1 : 2'd2;
  wire lat_out = lat_ff != '0 && lcnt_ff >= lat_ff;
  wire burst_end = bcnt_ff + 8'h1 >= ch_burst[sel_ff] || lat_out || last[sel_ff];
  wire [31:0] sw_in = ch_out[sel_ff];
  assign o_mst_valid = ms_ff == MS_BURST && can[sel_ff];
  assign o_mst_req.write = !rd_mode[sel_ff];
  assign o_mst_req.chan = sel_ff;
  assign o_mst_req.addr = ch_addr[sel_ff];
  assign o_mst_req.wdata = ch_swap[sel_ff] == 2'b01 ? {sw_in[23:16], sw_in[31:24], sw_in[7:0], sw_in[15:8]} :
                           ch_swap[sel_ff] == 2'b10 ? {sw_in[7:0], sw_in[15:8], sw_in[23:16], sw_in[31:24]} :
                           sw_in;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ms_ff <= MS_IDLE;
      sel_ff <= '0;
      bcnt_ff <= '0;
      lcnt_ff <= '0;
    end else begin
      unique case (ms_ff)
        MS_IDLE: begin
          bcnt_ff <= '0;
          lcnt_ff <= '0;
          if (want != '0 && !loading) begin
            sel_ff <= pick;
            ms_ff <= MS_BURST;
          end
        end
        MS_BURST: begin
          if (lcnt_ff != 8'hFF) lcnt_ff <= lcnt_ff + 8'h1;
          if (beat) bcnt_ff <= bcnt_ff + 8'h1;
          if ((beat && burst_end) || !can[sel_ff] || !bme) ms_ff <= MS_IDLE;
        end
      endcase
    end
  end

  // ---------------- checks ----------------
  property p_retry_load;
    @(posedge i_clk) disable iff (i_rst) (claim && loading) |=> (o_acc_retry && !o_acc_ack);
  endproperty
  a_retry_load: assert property (p_retry_load) else $error("access not retried while loading");
  property p_ch1_write;
    @(posedge i_clk) disable iff (i_rst) (o_mst_valid && o_mst_req.chan == 2'd0) |-> o_mst_req.write;
  endproperty
  a_ch1_write: assert property (p_ch1_write) else $error("first channel issued a fetch");
  property p_rev;
    @(posedge i_clk) disable iff (i_rst)
      (take && i_acc.cfg && !i_acc.wr && coff == CFG_CLASS) |=> o_acc_rdata[7:0] == REV_CODE;
  endproperty
  a_rev: assert property (p_rev) else $error("revision byte wrong");
  property p_bar_low;
    @(posedge i_clk) disable iff (i_rst)
      (take && i_acc.cfg && !i_acc.wr && coff == CFG_BAR) |=> o_acc_rdata[8:0] == 9'h0;
  endproperty
  a_bar_low: assert property (p_bar_low) else $error("base low bits not zero");
  property p_intpin;
    @(posedge i_clk) disable iff (i_rst)
      (take && i_acc.cfg && !i_acc.wr && coff == CFG_INTR) |=> o_acc_rdata[15:8] == INT_PIN_A;
  endproperty
  a_intpin: assert property (p_intpin) else $error("interrupt pin field wrong");
  property p_flag_set;
    @(posedge i_clk) disable iff (i_rst) i_evt_parity |=> stcmd_ff[ST_DPE];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("parity flag lost");
  property p_lat_bound;
    @(posedge i_clk) disable iff (i_rst)
      (ms_ff == MS_BURST && lat_out && beat) |=> ms_ff == MS_IDLE;
  endproperty
  a_lat_bound: assert property (p_lat_bound) else $error("burst outlived latency timer");
  property p_no_master_load;
    @(posedge i_clk) disable iff (i_rst) loading |-> !o_mst_valid;
  endproperty
  a_no_master_load: assert property (p_no_master_load) else $error("master active while loading");
  property p_load_ends;
    @(posedge i_clk) disable iff (i_rst) $rose(ld_ff == LD_STOP) |-> ##[1:1000] !loading;
  endproperty
  a_load_ends: assert property (p_load_ends) else $error("stop phase did not finish");
  c_burst: cover property (@(posedge i_clk) disable iff (i_rst) beat ##1 beat);
  c_read: cover property (@(posedge i_clk) disable iff (i_rst) beat && !o_mst_req.write);
  c_retry: cover property (@(posedge i_clk) disable iff (i_rst) o_acc_retry);
endmodule
`default_nettype wire

// ### pvd_host_model.sv
// host bridge model answering master beats
`timescale 1ns/100ps
`default_nettype none
module pvd_host_model import pvd_pkg::*; (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_mst_valid,
  input wire pvd_mreq_t i_mst_req,
  output logic o_mst_ready,
  output logic [31:0] o_mst_rdata,
  input wire logic i_ee_sda_oe,
  output logic o_ee_sda
);
  logic ph_ff = 1'b0;
  always_ff @(posedge i_clk) ph_ff <= ~ph_ff;
  // slow mode stalls every other cycle
  assign o_mst_ready = i_mst_valid && (!i_slow || ph_ff);
  assign o_mst_rdata = ~i_mst_req.addr;
  // pull-up and no memory fitted: loader sees no answer
  assign o_ee_sda = ~i_ee_sda_oe;
endmodule
`default_nettype wire

// ### pvd_dma_tb.sv
// self-checking bench for the pci video dma front end
`timescale 1ns/100ps
`default_nettype none
module pvd_dma_tb import pvd_pkg::*;;
  logic i_clk = 0, i_rst = 1, acc_v = 0, slow = 0, sda, ready, ack, retry, mv, sda_oe;
  pvd_acc_t acc = '0;
  pvd_mreq_t mreq;
  logic [3:0] evt = 0;
  logic [2:0] vv = 0, vrdy;
  logic [2:0][31:0] vd = '0;
  logic [31:0] rdata, rd, ma = 32'h2000_0000;
  logic [7:0] lf = 8'h55;
  logic [32:0] e, expq[$];
  logic [31:0] beatq[$];
  int failures = 0, tests_run = 0, cyc = 0, retries = 0;
  pvd_dma dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_acc_valid(acc_v), .i_acc(acc),
    .o_acc_ack(ack), .o_acc_retry(retry), .o_acc_rdata(rdata), .i_evt_parity(evt[3]),
    .i_evt_mabort(evt[2]), .i_evt_tabort(evt[1]), .i_evt_dparity(evt[0]),
    .o_mst_valid(mv), .o_mst_req(mreq), .i_mst_ready(ready), .i_mst_rdata(rd),
    .i_vid_odd(1'b0), .i_vid_valid(vv), .i_vid_data(vd), .i_vid_eof(3'h0),
    .o_vid_ready(vrdy), .o_rd_valid(), .o_rd_data(), .i_rd_ready(3'h7), .o_ee_scl_o(),
    .o_ee_scl_oe(), .o_ee_sda_o(), .o_ee_sda_oe(sda_oe), .i_ee_sda_i(sda));
  pvd_host_model host_u (.i_clk(i_clk), .i_slow(slow), .i_mst_valid(mv), .i_mst_req(mreq),
    .o_mst_ready(ready), .o_mst_rdata(rd), .i_ee_sda_oe(sda_oe), .o_ee_sda(sda));
  always #25 i_clk = ~i_clk;
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] x, s);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  // writes queue an unchecked note so notes pair with acks
  task automatic xfer(input logic c, w, input logic [31:0] a, d, x);
    @(posedge i_clk);
    acc_v <= 1;
    acc <= '{cfg: c, wr: w, addr: a, wdata: d, be: 4'hF};
    expq.push_back({~w, x});
    @(posedge i_clk);
    acc_v <= 0;
    #1;
    if (retry) begin
      retries++;
      void'(expq.pop_back());
    end
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 40000) begin
      failures++;
      print_verdict();
    end
    if (ack && expq.size() > 0) begin
      e = expq.pop_front();
      if (e[32]) check("rdata", e[31:0], rdata);
    end
    if (mv && ready && beatq.size() > 0) begin
      check("beat data", beatq.pop_front(), mreq.wdata);
      check("beat addr", ma, mreq.addr);
      check("beat dir", 32'h4, {29'h0, mreq.write, mreq.chan});
      ma += 4;
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 0;
    do xfer(1, 0, CFG_CLASS, 0, {CLASS_CODE, 8'h3C}); while (retry);
    check("retry", 1, {31'h0, retries > 0});
    xfer(1, 0, CFG_IDS, 0, 32'h5A5A_A5A5);
    xfer(1, 0, CFG_SUBSYS, 0, SUBSYS_DEF);
    lf = nx(lf);
    xfer(1, 1, CFG_INTR, {24'hFFFFFF, lf}, 0);
    xfer(1, 0, CFG_INTR, 0, {MAX_LAT_DEF, MIN_GNT_DEF, INT_PIN_A, lf});
    lf = nx(lf);
    xfer(1, 1, CFG_LAT, {16'hFFFF, lf, 8'hFF}, 0);
    xfer(1, 0, CFG_LAT, 0, {16'h0, lf, 8'h0});
    xfer(1, 1, 32'h14, 32'hFFFF_FFFF, 0);
    xfer(1, 0, 32'h14, 0, 0);
    xfer(1, 1, CFG_BAR, 32'hFFFF_FFFF, 0);
    xfer(1, 0, CFG_BAR, 0, 32'hFFFF_FE00);
    xfer(1, 1, CFG_BAR, 32'h1000_0000, 0);
    xfer(1, 1, CFG_STCMD, 32'hFFFF_FFFF, 0);
    xfer(1, 0, CFG_STCMD, 0, 32'h0280_0246);
    evt <= 4'hF;
    @(posedge i_clk);
    evt <= 0;
    xfer(1, 0, CFG_STCMD, 0, 32'hB380_0246);
    xfer(1, 1, CFG_STCMD, 32'hB100_0246, 0);
    xfer(1, 0, CFG_STCMD, 0, 32'h0280_0246);
    xfer(0, 1, 32'h1000_0000, ma, 0);
    xfer(0, 0, 32'h1000_0000, 0, ma);
    // field parity input is even, so the job starts from the even base
    xfer(0, 1, 32'h1000_0004, ma, 0);
    xfer(0, 0, 32'h1000_0004, 0, ma);
    xfer(0, 1, 32'h1000_0034, 32'hFFFF_FFFF, 0);
    xfer(0, 0, 32'h1000_0034, 0, NUM_MASK);
    xfer(0, 1, 32'h1000_0014, 32'hFFFF_FFFF, 0);
    xfer(0, 0, 32'h1000_0014, 0, 0);
    xfer(1, 1, CFG_LAT, 0, 0);
    // settings written while idle, then planar write job armed
    xfer(0, 1, 32'h1000_0018, 32'h0004_0101, 0);
    slow <= 1;
    @(posedge i_clk);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      beatq.push_back({4{lf}});
      vv[0] <= 1;
      vd[0] <= {4{lf}};
      do @(posedge i_clk); while (!vrdy[0]);
    end
    vv[0] <= 0;
    repeat (200) @(posedge i_clk);
    check("beats left", 0, 32'(beatq.size()));
    print_verdict();
  end
endmodule
`default_nettype wire
